// ==== hw/viu_vectored_irq_unit.sv ====
`timescale 1ns/1ps
module viu_vectored_irq_unit #(
    parameter int          NUM_INPUTS = 32,
    parameter int          NUM_SLOTS  = 16,
    parameter logic [31:0] PERIPH_ID  = viu_pkg::PERIPH_ID_DEF,
    parameter logic [31:0] CELL_ID    = viu_pkg::CELL_ID_DEF
) (
    // clock, reset, enable
    input  wire logic                  mclk_in,
    input  wire logic                  reset_in,
    input  wire logic                  ce_in,
    // local ahb slave
    input  wire viu_pkg::viu_ahb_req_t ahb_in,
    output viu_pkg::viu_ahb_rsp_t      ahb_out,
    // interrupt sources
    input  wire logic [31:0]           irq_lines_in,
    // processor side
    output logic                       irq_out,
    output logic                       fiq_out,
    output logic                       wake_out
);
    import viu_pkg::*;

    // decode and source fields are sized for exactly 32 inputs and up to 16 slots
    // fewer slots leave upper slot offsets reading zero
    if (NUM_INPUTS != 32 || NUM_SLOTS < 1 || NUM_SLOTS > 16) begin : g_bad_params
        $error("viu_vectored_irq_unit: unsupported NUM_INPUTS or NUM_SLOTS");
    end

    // input synchroniser stages
    logic [31:0]          sync1_reg;
    logic [31:0]          sync2_reg;

    // software-visible control state
    logic [31:0]          select_reg;
    logic [31:0]          enable_reg;
    logic [31:0]          forced_reg;
    logic                 guard_reg;
    logic [31:0]          fallback_reg;

    // vector tables and open levels
    logic [31:0]          slot_addr_reg [NUM_SLOTS];
    viu_slot_ctrl_t       slot_ctrl_reg [NUM_SLOTS];
    logic [NUM_SLOTS:0]   in_service_reg;

    // bus data phase
    viu_bus_state_t       state_reg;
    viu_ahb_rsp_t         rsp_reg;
    logic [11:0]          addr_reg;
    logic                 wr_pend_reg;

    // registered processor lines
    logic                 irq_reg;
    logic                 fiq_reg;
    logic                 wake_reg;

    // request views
    logic [31:0]          raw;
    logic [31:0]          irq_stat;
    logic [31:0]          fiq_stat;
    logic [NUM_SLOTS-1:0] slot_hit;

    // bus decode
    logic                 accept;
    logic                 hit_base;
    logic                 refuse;
    logic                 rd_fire;
    logic                 wr_fire;
    logic [3:0]           slot_idx;
    logic                 in_slot_addr;
    logic                 in_slot_ctrl;

    // priority pick and read path
    logic                 pick_found;
    logic [3:0]           pick_idx;
    logic                 pick_blocked;
    logic [31:0]          vect_value;
    logic [31:0]          rd_value;
    logic [NUM_SLOTS:0]   top_service;

    // every output comes straight from a flop
    assign ahb_out  = rsp_reg;
    assign irq_out  = irq_reg;
    assign fiq_out  = fiq_reg;
    assign wake_out = wake_reg;

    // two-stage synchroniser: sources come from other blocks and chip pins
    // only sync2 reads sync1, so metastability never fans out
    // ce_in low holds every flop, bus answer included
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sync1_reg <= 32'h0;
            sync2_reg <= 32'h0;
        end else if (ce_in) begin
            sync1_reg <= irq_lines_in;
            sync2_reg <= sync1_reg;
        end
    end

    // request views
    assign raw      = sync2_reg | forced_reg;
    assign irq_stat = raw & enable_reg & ~select_reg;
    assign fiq_stat = raw & enable_reg & select_reg;

    // processor lines, registered so they come straight from flops
    // one edge of latency keeps glitches off the core
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            irq_reg  <= 1'b0;
            fiq_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else if (ce_in) begin
            irq_reg  <= |irq_stat;
            fiq_reg  <= |fiq_stat;
            wake_reg <= |(raw & enable_reg);
        end
    end

    // address phase qualification
    // a refused access captures its offset but fires no strobe
    // privilege comes from bit 1 of the protection code
    assign accept   = ahb_in.sel & ahb_in.trans[TRANS_ACTIVE_BIT] & ahb_in.ready;
    assign hit_base = (ahb_in.addr[31:12] == BASE_BUFFERED) ||
                      (ahb_in.addr[31:12] == BASE_UNBUFFERED) ||
                      (ahb_in.addr[31:12] == BASE_HIGH);
    assign refuse   = ~hit_base | (guard_reg & ~ahb_in.prot[PROT_PRIV_BIT]);

    // data phase strobes and decode of the captured offset
    assign rd_fire      = (state_reg == BUS_READ);
    assign wr_fire      = wr_pend_reg;
    assign slot_idx     = addr_reg[5:2];
    assign in_slot_addr = (addr_reg[11:6] == OFS_SLOT_ADDR[11:6]) && (32'(slot_idx) < NUM_SLOTS);
    assign in_slot_ctrl = (addr_reg[11:6] == OFS_SLOT_CTRL[11:6]) && (32'(slot_idx) < NUM_SLOTS);

    // bus phase machine; reads take one wait state so a write just ahead is seen
    // a new address is taken whenever readyout is high
    // errors take two cycles so the master can cancel
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_reg   <= BUS_IDLE;
            rsp_reg     <= '{rdata: 32'h0, readyout: 1'b1, resp: 1'b0};
            addr_reg    <= 12'h0;
            wr_pend_reg <= 1'b0;
        end else if (ce_in) begin
            wr_pend_reg <= 1'b0;
            if (accept) begin
                addr_reg <= ahb_in.addr[11:0];
            end
            case (state_reg)
                BUS_IDLE, BUS_ERR2: begin
                    if (accept && refuse) begin
                        state_reg        <= BUS_ERR1;
                        rsp_reg.readyout <= 1'b0;
                        rsp_reg.resp     <= 1'b1;
                    end else if (accept && !ahb_in.write) begin
                        state_reg        <= BUS_READ;
                        rsp_reg.readyout <= 1'b0;
                        rsp_reg.resp     <= 1'b0;
                    end else begin
                        state_reg        <= BUS_IDLE;
                        rsp_reg.readyout <= 1'b1;
                        rsp_reg.resp     <= 1'b0;
                        wr_pend_reg      <= accept;
                    end
                end
                BUS_READ: begin
                    state_reg        <= BUS_IDLE;
                    rsp_reg.rdata    <= rd_value;
                    rsp_reg.readyout <= 1'b1;
                end
                BUS_ERR1: begin
                    state_reg        <= BUS_ERR2;
                    rsp_reg.readyout <= 1'b1;
                end
                default: begin
                    state_reg        <= BUS_IDLE;
                    rsp_reg.readyout <= 1'b1;
                    rsp_reg.resp     <= 1'b0;
                end
            endcase
        end
    end

    // per-slot request match on the IRQ side only
    // fiq-routed sources are never vectored
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
        assign slot_hit[g] = slot_ctrl_reg[g].en & irq_stat[slot_ctrl_reg[g].src];
    end

    // priority pick: lowest slot wins, stopping at the level now in service
    // an open level masks itself and all higher-numbered slots
    always_comb begin
        pick_found   = 1'b0;
        pick_blocked = 1'b0;
        pick_idx     = 4'h0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (!pick_found && !pick_blocked) begin
                if (in_service_reg[i]) begin
                    pick_blocked = 1'b1;
                end else if (slot_hit[i]) begin
                    pick_found = 1'b1;
                    pick_idx   = 4'(i);
                end
            end
        end
    end

    // handler address shown to software
    // with the pick masked, software gets the fallback
    assign vect_value = pick_found ? slot_addr_reg[pick_idx] : fallback_reg;

    // highest-priority level in service, the one a handler-end write retires
    // scanned downward so the lowest open index wins
    always_comb begin
        top_service = '0;
        for (int i = NUM_SLOTS; i >= 0; i--) begin
            if (in_service_reg[i]) begin
                top_service    = '0;
                top_service[i] = 1'b1;
            end
        end
    end

    // in-service levels: a vector read opens a level, a vector write closes it
    // the fallback level sits above the top slot
    // polling other offsets never touches the levels
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            in_service_reg <= '0;
        end else if (ce_in) begin
            if (rd_fire && addr_reg == OFS_VECT_ADDR) begin
                if (pick_found) begin
                    in_service_reg[pick_idx] <= 1'b1;
                end else if (|irq_stat && !pick_blocked) begin
                    in_service_reg[NUM_SLOTS] <= 1'b1;
                end
            end else if (wr_fire && addr_reg == OFS_VECT_ADDR) begin
                in_service_reg <= in_service_reg & ~top_service;
            end
        end
    end

    // routing, guard and fallback address
    // the guard keeps bit zero only
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            select_reg   <= 32'h0;
            guard_reg    <= 1'b0;
            fallback_reg <= 32'h0;
        end else if (ce_in && wr_fire) begin
            if (addr_reg == OFS_SELECT) begin
                select_reg <= ahb_in.wdata;
            end else if (addr_reg == OFS_GUARD) begin
                guard_reg <= ahb_in.wdata[GUARD_BIT];
            end else if (addr_reg == OFS_FALLBACK) begin
                fallback_reg <= ahb_in.wdata;
            end
        end
    end

    // enables: set and clear live at separate offsets so they never meet
    // a write lands on the edge ending its data phase
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            enable_reg <= 32'h0;
        end else if (ce_in && wr_fire) begin
            if (addr_reg == OFS_ENABLE_SET) begin
                enable_reg <= enable_reg | ahb_in.wdata;
            end else if (addr_reg == OFS_ENABLE_CLR) begin
                enable_reg <= enable_reg & ~ahb_in.wdata;
            end
        end
    end

    // software-forced requests
    // forcing sits ahead of masking, so raw shows it
    // a forced bit stays until a clear write removes it
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            forced_reg <= 32'h0;
        end else if (ce_in && wr_fire) begin
            if (addr_reg == OFS_FORCE_SET) begin
                forced_reg <= forced_reg | ahb_in.wdata;
            end else if (addr_reg == OFS_FORCE_CLR) begin
                forced_reg <= forced_reg & ~ahb_in.wdata;
            end
        end
    end

    // slot tables; addresses are cleared too so nothing jumps to garbage
    // writes past NUM_SLOTS land nowhere
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_addr_reg[i] <= 32'h0;
                slot_ctrl_reg[i] <= '0;
            end
        end else if (ce_in && wr_fire) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (in_slot_addr && slot_idx == 4'(i)) begin
                    slot_addr_reg[i] <= ahb_in.wdata;
                end
                if (in_slot_ctrl && slot_idx == 4'(i)) begin
                    slot_ctrl_reg[i] <= viu_slot_ctrl_t'(ahb_in.wdata[CTRL_W-1:0]);
                end
            end
        end
    end

    // read multiplexer; unlisted offsets read zero
    // it decodes the offset captured at the address phase
    // each id offset returns one byte in bits 7:0
    always_comb begin
        rd_value = 32'h0;
        if (addr_reg == OFS_IRQ_STAT) begin
            rd_value = irq_stat;
        end else if (addr_reg == OFS_FIQ_STAT) begin
            rd_value = fiq_stat;
        end else if (addr_reg == OFS_RAW_STAT) begin
            rd_value = raw;
        end else if (addr_reg == OFS_SELECT) begin
            rd_value = select_reg;
        end else if (addr_reg == OFS_ENABLE_SET) begin
            rd_value = enable_reg;
        end else if (addr_reg == OFS_FORCE_SET) begin
            rd_value = forced_reg;
        end else if (addr_reg == OFS_GUARD) begin
            rd_value = 32'(guard_reg);
        end else if (addr_reg == OFS_VECT_ADDR) begin
            rd_value = vect_value;
        end else if (addr_reg == OFS_FALLBACK) begin
            rd_value = fallback_reg;
        end else if (in_slot_addr) begin
            rd_value = slot_addr_reg[slot_idx];
        end else if (in_slot_ctrl) begin
            rd_value = 32'(slot_ctrl_reg[slot_idx]);
        end else if (addr_reg[11:4] == OFS_PERIPH_ID[11:4]) begin
            rd_value = 32'(PERIPH_ID[{addr_reg[3:2], 3'h0} +: 8]);
        end else if (addr_reg[11:4] == OFS_CELL_ID[11:4]) begin
            rd_value = 32'(CELL_ID[{addr_reg[3:2], 3'h0} +: 8]);
        end
    end

endmodule

// ==== pkg/viu_pkg.sv ====
// Function
// - irq_masked_status reads active requests routed to IRQ after enable masking.
// - fiq_masked_status reads active requests routed to FIQ after enable masking.
// - raw_request_status reads all inputs ORed with forced bits, before masking.
// - select bit zero routes an input to IRQ, one routes it to FIQ.
// - writing ones to input_enable_set sets enables; zeros ignored; reset clears all.
// - writing ones to input_enable_clear clears matching enables; zeros ignored.
// - ones written to forced_request_set force inputs active; zeros ignored; readable.
// - ones written to forced_request_clear clear matching forced bits; zeros ignored.
// - with guard bit set only privileged accesses are served; bit resets to zero.
// - active_handler_address shows current handler; write at handler end advances priority.
// - fallback_handler_address serves every interrupt not owned by a vector slot.
// - sixteen readable, writable slot handler address registers, one per slot.
// - wake signal raised whenever an enabled request is active.
// - register block answers at buffered, unbuffered and high base windows.
// - two groups of four read-only identification bytes at block top.
// - slot control holds five-bit source and enable bit cleared at reset.
// - slot zero has highest priority, higher slots successively lower.
package viu_pkg;

    // register offsets inside the 4 KB block
    localparam logic [11:0] OFS_IRQ_STAT   = 12'h000;
    localparam logic [11:0] OFS_FIQ_STAT   = 12'h004;
    localparam logic [11:0] OFS_RAW_STAT   = 12'h008;
    localparam logic [11:0] OFS_SELECT     = 12'h00c;
    localparam logic [11:0] OFS_ENABLE_SET = 12'h010;
    localparam logic [11:0] OFS_ENABLE_CLR = 12'h014;
    localparam logic [11:0] OFS_FORCE_SET  = 12'h018;
    localparam logic [11:0] OFS_FORCE_CLR  = 12'h01c;
    localparam logic [11:0] OFS_GUARD      = 12'h020;
    localparam logic [11:0] OFS_VECT_ADDR  = 12'h030;
    localparam logic [11:0] OFS_FALLBACK   = 12'h034;
    localparam logic [11:0] OFS_SLOT_ADDR  = 12'h100;
    localparam logic [11:0] OFS_SLOT_CTRL  = 12'h200;
    localparam logic [11:0] OFS_PERIPH_ID  = 12'hfe0;
    localparam logic [11:0] OFS_CELL_ID    = 12'hff0;

    // block base windows, address bits 31:12
    localparam logic [19:0] BASE_BUFFERED   = 20'h2f000;
    localparam logic [19:0] BASE_UNBUFFERED = 20'h1f000;
    localparam logic [19:0] BASE_HIGH       = 20'hfffff;

    // field positions and widths
    localparam int SRC_W           = 5;
    localparam int CTRL_W          = SRC_W + 1;
    localparam int GUARD_BIT       = 0;
    localparam int TRANS_ACTIVE_BIT = 1;
    localparam int PROT_PRIV_BIT   = 1;

    // identification words, arbitrary neutral values
    localparam logic [31:0] PERIPH_ID_DEF = 32'h4d3c2b1a;
    localparam logic [31:0] CELL_ID_DEF   = 32'h8877e6d5;

    typedef struct packed {
        logic               en;
        logic [SRC_W-1:0]   src;
    } viu_slot_ctrl_t;

    typedef struct packed {
        logic               sel;
        logic [1:0]         trans;
        logic               write;
        logic [3:0]         prot;
        logic [31:0]        addr;
        logic [31:0]        wdata;
        logic               ready;
    } viu_ahb_req_t;

    typedef struct packed {
        logic [31:0]        rdata;
        logic               readyout;
        logic               resp;
    } viu_ahb_rsp_t;

    // bus phase, gray along idle -> read -> idle and err1 -> err2 -> idle
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_READ = 2'h1,
        BUS_ERR1 = 2'h3,
        BUS_ERR2 = 2'h2
    } viu_bus_state_t;

endpackage

// ==== verification/viu_source_model.sv ====
`timescale 1ns/1ps
module viu_source_model (
    // clock
    input  wire logic        mclk_in,
    // bench requests and pace
    input  wire logic [31:0] req_in,
    input  wire logic        slow_in,
    // request lines to the controller
    output logic [31:0]      lines_out
);
    logic [31:0] now_reg = 32'h0;
    logic [31:0] hold_reg = 32'h0;
    // peripherals hold levels; a slow one raises its level a cycle late
    always_ff @(posedge mclk_in) begin
        now_reg <= req_in;
        hold_reg <= now_reg;
    end
    assign lines_out = slow_in ? hold_reg : now_reg;
endmodule

// ==== verification/viu_checker.sv ====
`timescale 1ns/1ps
module viu_checker (
    // clock and control
    input wire logic                  mclk_in,
    input wire logic                  reset_in,
    input wire logic                  ce_in,
    // bus
    input wire viu_pkg::viu_ahb_req_t ahb_in,
    input wire viu_pkg::viu_ahb_rsp_t ahb_out,
    // interrupt side
    input wire logic [31:0]           irq_lines_in,
    input wire logic                  irq_out,
    input wire logic                  fiq_out,
    input wire logic                  wake_out
);
    import viu_pkg::*;
    logic taken;
    logic win;
    logic deny;
    logic guard_reg;
    logic guard_wr_reg;
    // decode of the address phase as the slave should see it
    assign taken = ahb_in.sel && ahb_in.trans[1] && ahb_in.ready && ce_in;
    assign win = ahb_in.addr[31:12] inside {BASE_BUFFERED, BASE_UNBUFFERED, BASE_HIGH};
    assign deny = guard_reg && !ahb_in.prot[PROT_PRIV_BIT];
    // shadow of the guard bit, so refusals can be predicted from the bus alone
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            guard_wr_reg <= 1'b0;
            guard_reg <= 1'b0;
        end else if (ce_in) begin
            guard_wr_reg <= taken && ahb_in.write && win && !deny && ahb_in.addr[11:0] == OFS_GUARD;
            if (guard_wr_reg) begin
                guard_reg <= ahb_in.wdata[GUARD_BIT];
            end
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_rst_quiet;
        $fell(reset_in) |-> !irq_out && !fiq_out && !wake_out && ahb_out.readyout && !ahb_out.resp;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
    property p_wake_eq;
        wake_out == (irq_out || fiq_out);
    endproperty
    a_wake_eq: assert property (p_wake_eq) else $error("wake disagrees with irq and fiq");
    property p_read_walk;
        taken && !ahb_in.write && win && !deny |=> !ahb_out.readyout && !ahb_out.resp ##1 ahb_out.readyout;
    endproperty
    a_read_walk: assert property (p_read_walk) else $error("read wait state wrong");
    property p_write_ok;
        taken && ahb_in.write && win && !deny |=> ahb_out.readyout && !ahb_out.resp;
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("served write stalled or refused");
    sequence s_error;
        !ahb_out.readyout && ahb_out.resp ##1 ahb_out.readyout && ahb_out.resp;
    endsequence
    property p_bad_win;
        taken && !win |=> s_error;
    endproperty
    a_bad_win: assert property (p_bad_win) else $error("outside address not refused");
    property p_guard_deny;
        taken && win && deny |=> s_error;
    endproperty
    a_guard_deny: assert property (p_guard_deny) else $error("user access not refused");
    property p_idle_ready;
        !taken |=> ahb_out.readyout;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("wait state without request");
    property p_rdata_hold;
        ahb_out.readyout || ahb_out.resp |=> $stable(ahb_out.rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    property p_quiet;
        (!(taken && ahb_in.write) && $stable(irq_lines_in)) [*6] |=> $stable({irq_out, fiq_out, wake_out});
    endproperty
    a_quiet: assert property (p_quiet) else $error("request outputs moved without cause");
    c_read: cover property (taken && !ahb_in.write && win && !deny);
    c_deny: cover property (taken && deny);
    c_wake: cover property ($rose(wake_out));
endmodule

bind viu_vectored_irq_unit viu_checker chk (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_in),
    .ahb_in(ahb_in), .ahb_out(ahb_out), .irq_lines_in(irq_lines_in), .irq_out(irq_out),
    .fiq_out(fiq_out), .wake_out(wake_out));

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import viu_pkg::*;
    localparam logic [11:0] ZERO_OFS [11] = '{OFS_IRQ_STAT, OFS_FIQ_STAT, OFS_RAW_STAT, OFS_SELECT,
        OFS_ENABLE_SET, OFS_ENABLE_CLR, OFS_FORCE_SET, OFS_FORCE_CLR, OFS_GUARD, OFS_SLOT_CTRL, 12'h040};
    logic         mclk_in;
    logic         reset_in;
    logic         slow;
    logic         ce;
    logic [31:0]  lines_req;
    logic [31:0]  irq_lines;
    logic         irq_o;
    logic         fiq_o;
    logic         wake_o;
    viu_ahb_req_t req_d;
    viu_ahb_req_t req;
    viu_ahb_rsp_t rsp;
    logic [19:0]  base;
    logic [31:0]  seed;
    logic [31:0]  rv;
    logic         er;
    logic [31:0]  sel;
    logic [31:0]  en;
    logic [31:0]  frc;
    logic [31:0]  raw;
    int           fails;
    int           cmp_count;

    viu_vectored_irq_unit uut (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce), .ahb_in(req),
        .ahb_out(rsp), .irq_lines_in(irq_lines), .irq_out(irq_o), .fiq_out(fiq_o), .wake_out(wake_o));
    viu_source_model src (.mclk_in(mclk_in), .req_in(lines_req), .slow_in(slow), .lines_out(irq_lines));

    // single slave: ready in follows readyout, else a stalled read looks taken twice
    always_comb begin
        req = req_d;
        req.ready = rsp.readyout;
    end
    // clock
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one transfer, entered just after an edge; result taken where readyout is sampled high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic pr);
        int n;
        req_d.sel <= 1'b1;
        req_d.trans <= 2'h2;
        req_d.write <= w;
        req_d.addr <= a;
        req_d.prot <= {2'h0, pr, 1'b1};
        @(posedge mclk_in);
        req_d.sel <= 1'b0;
        req_d.trans <= 2'h0;
        req_d.wdata <= d;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (rsp.readyout !== 1'b1 && n < 8);
        rv = rsp.rdata;
        er = rsp.resp;
    endtask
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        bus(1'b1, {base, ofs}, d, 1'b1);
    endtask
    task automatic rdc(input logic [11:0] ofs, input logic [31:0] exp);
        bus(1'b0, {base, ofs}, 32'h0, 1'b1);
        check(rv, exp);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (6000) @(posedge mclk_in);
        fails++;
        wrap_up;
    end

    initial begin
        req_d = '0;
        lines_req = 32'h0;
        slow = 1'b0;
        ce = 1'b1;
        base = BASE_BUFFERED;
        seed = 32'h05ca;
        fails = 0;
        cmp_count = 0;
        reset_in = 1'b1;
        repeat (3) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        // reset state, unmapped offset and id bytes
        foreach (ZERO_OFS[i]) rdc(ZERO_OFS[i], 32'h0);
        for (int k = 0; k < 4; k++) begin
            rdc(OFS_PERIPH_ID + 12'(4 * k), {24'h0, PERIPH_ID_DEF[8 * k +: 8]});
            rdc(OFS_CELL_ID + 12'(4 * k), {24'h0, CELL_ID_DEF[8 * k +: 8]});
        end
        // random lines, routing, enables and forcing, rotating through the windows
        for (int i = 0; i < 9; i++) begin
            base = (i % 3 == 0) ? BASE_BUFFERED : (i % 3 == 1) ? BASE_UNBUFFERED : BASE_HIGH;
            wr(OFS_ENABLE_CLR, 32'hffffffff);
            wr(OFS_FORCE_CLR, 32'hffffffff);
            seed = lfsr(seed);
            lines_req <= seed & lfsr(seed);
            slow <= seed[3];
            seed = lfsr(seed);
            sel = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : seed;
            wr(OFS_SELECT, sel);
            seed = lfsr(seed);
            en = seed;
            wr(OFS_ENABLE_SET, en);
            seed = lfsr(seed);
            wr(OFS_ENABLE_SET, seed);
            en = en | seed;
            seed = lfsr(seed);
            wr(OFS_ENABLE_CLR, seed);
            en = en & ~seed;
            seed = lfsr(seed);
            frc = (i == 2) ? 32'h0 : seed;
            wr(OFS_FORCE_SET, frc);
            seed = lfsr(seed);
            wr(OFS_FORCE_CLR, seed & lfsr(seed));
            frc = frc & ~(seed & lfsr(seed));
            repeat (4) @(posedge mclk_in);
            raw = lines_req | frc;
            rdc(OFS_RAW_STAT, raw);
            rdc(OFS_SELECT, sel);
            rdc(OFS_ENABLE_SET, en);
            rdc(OFS_FORCE_SET, frc);
            rdc(OFS_IRQ_STAT, raw & en & ~sel);
            rdc(OFS_FIQ_STAT, raw & en & sel);
            check({29'h0, irq_o, fiq_o, wake_o}, {29'h0, |(raw & en & ~sel), |(raw & en & sel), |(raw & en)});
        end
        // vectored pick: two armed slots, a disarmed one, then the fallback
        lines_req <= 32'h0;
        wr(OFS_SELECT, 32'h0);
        wr(OFS_ENABLE_SET, 32'hffffffff);
        wr(OFS_FORCE_CLR, 32'hffffffff);
        wr(OFS_FALLBACK, 32'h0000fa11);
        for (int k = 0; k < 16; k++) begin
            wr(OFS_SLOT_ADDR + 12'(4 * k), 32'h1000 + 32'(k));
            wr(OFS_SLOT_CTRL + 12'(4 * k), 32'h1f);
            rdc(OFS_SLOT_ADDR + 12'(4 * k), 32'h1000 + 32'(k));
        end
        wr(OFS_SLOT_CTRL + 12'h024, 32'h22);
        wr(OFS_SLOT_CTRL + 12'h00c, 32'h27);
        wr(OFS_SLOT_CTRL, 32'h05);
        rdc(OFS_SLOT_CTRL + 12'h00c, 32'h27);
        wr(OFS_FORCE_SET, 32'h000000a4);
        repeat (2) @(posedge mclk_in);
        rdc(OFS_VECT_ADDR, 32'h1003);
        rdc(OFS_VECT_ADDR, 32'h0000fa11);
        wr(OFS_VECT_ADDR, 32'h0);
        wr(OFS_FORCE_CLR, 32'h80);
        rdc(OFS_VECT_ADDR, 32'h1009);
        wr(OFS_VECT_ADDR, 32'h0);
        wr(OFS_FORCE_CLR, 32'h04);
        rdc(OFS_VECT_ADDR, 32'h0000fa11);
        wr(OFS_VECT_ADDR, 32'h0);
        // privileged-only access: with the guard set user accesses are refused and change nothing, then served once it clears
        wr(OFS_GUARD, 32'h1);
        bus(1'b1, {base, OFS_ENABLE_CLR}, 32'hffffffff, 1'b0);
        check({31'h0, er}, 32'h1);
        rdc(OFS_ENABLE_SET, 32'hffffffff);
        rdc(OFS_GUARD, 32'h1);
        wr(OFS_GUARD, 32'h0);
        bus(1'b0, {base, OFS_GUARD}, 32'h0, 1'b0);
        check({31'h0, er}, 32'h0);
        bus(1'b0, 32'h2e000010, 32'h0, 1'b1);
        check({31'h0, er}, 32'h1);
        // clock enable low: a write is dropped
        ce <= 1'b0;
        wr(OFS_ENABLE_CLR, 32'hffffffff);
        ce <= 1'b1;
        rdc(OFS_ENABLE_SET, 32'hffffffff);
        wrap_up;
    end
endmodule
